// file: logic/tap_pkg.sv
// Shared constants and types for the boundary-scan test port.
package tap_pkg;

    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    localparam int BSR_LEN_DEF = 109;
    localparam int OE_CELL = 108;

    // Instruction codes, fixed for this port.
    localparam logic [2:0] OP_EXTEST = 3'h0;
    localparam logic [2:0] OP_IDCODE = 3'h1;
    localparam logic [2:0] OP_SAMPLE_Z = 3'h2;
    localparam logic [2:0] OP_RSVD_A = 3'h3;
    localparam logic [2:0] OP_SAMPLE = 3'h4;
    localparam logic [2:0] OP_RSVD_B = 3'h5;
    localparam logic [2:0] OP_RSVD_C = 3'h6;
    localparam logic [2:0] OP_BYPASS = 3'h7;

    localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
    localparam logic [2:0] RESET_ONES = 3'h5;

    // Identification value; the value is arbitrary.
    localparam logic [31:0] ID_VALUE_DEF = 32'h0000_0001;

    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'hA,
        ST_SHIFT_IR = 4'hB,
        ST_EXIT1_IR = 4'hC,
        ST_PAUSE_IR = 4'hD,
        ST_EXIT2_IR = 4'hE,
        ST_UPD_IR = 4'hF
    } tap_state_t;

endpackage

// file: logic/bsr_if.sv
// Control and data path between the test-port controller and its boundary chain.
`timescale 1ns/1ps
`default_nettype none
interface bsr_if #(parameter int LEN = 109);
    logic capture;
    logic shift;
    logic update;
    logic preset;
    logic sin;
    logic sout;
    logic [LEN-1:0] drive;

    modport ctrl (output capture, output shift, output update, output preset, output sin,
                  input sout, input drive);
    modport chain (input capture, input shift, input update, input preset, input sin,
                   output sout, output drive);
endinterface
`default_nettype wire

// file: logic/bsr_chain.sv
// Boundary scan chain: pin sampler, shift stage and update latches.
`timescale 1ns/1ps
`default_nettype none
module bsr_chain #(
    parameter int LEN = 109
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [LEN-1:0] pin_i,
    bsr_if.chain bus
);
    typedef struct packed {
        logic [LEN-1:0] s1;
        logic [LEN-1:0] s2;
        logic [LEN-1:0] sh;
        logic [LEN-1:0] upd;
    } chain_t;

    localparam logic [LEN-1:0] UPD_PRESET = LEN'(1) << tap_pkg::OE_CELL;

    chain_t c_q;
    chain_t c_d;

    always_comb
    begin
        c_d = c_q;
        // Pins live in the memory's clock domain, so they are synchronised first.
        c_d.s1 = pin_i;
        c_d.s2 = c_q.s1;
        if (bus.capture)
        begin
            c_d.sh = c_q.s2;
        end
        else if (bus.shift)
        begin
            c_d.sh = {bus.sin, c_q.sh[LEN-1:1]};
        end
        if (bus.preset)
        begin
            c_d.upd = UPD_PRESET;
        end
        else if (bus.update)
        begin
            c_d.upd = c_q.sh;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            c_q <= {{(3*LEN){1'b0}}, UPD_PRESET};
        end
        else if (ce_i)
        begin
            c_q <= c_d;
        end
    end

    assign bus.sout = c_q.sh[0];
    assign bus.drive = c_q.upd;

    a_shift_msb_in: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && bus.shift && !bus.capture) |=> (c_q.sh[LEN-1] == $past(bus.sin)))
        else $error("serial input did not enter the chain msb");

    a_oe_cell_preset: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && bus.preset) |=> c_q.upd[tap_pkg::OE_CELL])
        else $error("output enable cell not preset high");
endmodule
`default_nettype wire

// file: logic/tap_port.sv
// Boundary-scan test access port, sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module tap_port #(
    parameter int BSR_LEN = tap_pkg::BSR_LEN_DEF,
    parameter logic [31:0] ID_VALUE = tap_pkg::ID_VALUE_DEF
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [BSR_LEN-1:0] pin_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic q_bus_oe_o,
    output logic extest_o,
    output logic [BSR_LEN-1:0] pin_drive_o
);
    typedef struct packed {
        logic [2:0] tck_s;
        logic [1:0] tms_s;
        logic [1:0] tdi_s;
        tap_pkg::tap_state_t st;
        logic [2:0] ir_sh;
        logic [2:0] ir;
        logic byp;
        logic [31:0] id_sh;
        logic tdo;
        logic tdo_oe;
        logic q_oe;
        logic extest;
        logic [2:0] ones;
    } port_t;

    port_t s_q;
    port_t s_d;
    tap_pkg::tap_state_t nxt;
    logic rise_ev;
    logic fall_ev;
    logic tms;
    logic tdi;
    logic sel_bsr;
    logic sel_id;

    bsr_if #(.LEN(BSR_LEN)) bif ();

    bsr_chain #(.LEN(BSR_LEN)) u_chain (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .pin_i(pin_i),
        .bus(bif.chain)
    );

    assign rise_ev = ce_i && s_q.tck_s[1] && !s_q.tck_s[2];
    assign fall_ev = ce_i && !s_q.tck_s[1] && s_q.tck_s[2];
    assign tms = s_q.tms_s[1];
    assign tdi = s_q.tdi_s[1];

    // Reserved codes fall through to bypass so the chain never breaks.
    assign sel_id = (s_q.ir == tap_pkg::OP_IDCODE);
    assign sel_bsr = (s_q.ir == tap_pkg::OP_EXTEST) || (s_q.ir == tap_pkg::OP_SAMPLE)
                     || (s_q.ir == tap_pkg::OP_SAMPLE_Z);

    always_comb
    begin
        nxt = s_q.st;
        case (s_q.st)
            tap_pkg::ST_RESET: nxt = tms ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
            tap_pkg::ST_IDLE: nxt = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR: nxt = tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
            tap_pkg::ST_CAP_DR: nxt = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_SHIFT_DR: nxt = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_EXIT1_DR: nxt = tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_PAUSE_DR: nxt = tms ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_EXIT2_DR: nxt = tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_UPD_DR: nxt = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR: nxt = tms ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
            tap_pkg::ST_CAP_IR: nxt = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_SHIFT_IR: nxt = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_EXIT1_IR: nxt = tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_PAUSE_IR: nxt = tms ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_EXIT2_IR: nxt = tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_UPD_IR: nxt = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            default: nxt = tap_pkg::ST_RESET;
        endcase
    end

    // Capture, shift and update act on the same rise that the controller sees; preset holds on every enabled clock in reset.
    assign bif.capture = rise_ev && sel_bsr && (s_q.st == tap_pkg::ST_CAP_DR);
    assign bif.shift = rise_ev && sel_bsr && (s_q.st == tap_pkg::ST_SHIFT_DR);
    assign bif.update = rise_ev && sel_bsr && (s_q.st == tap_pkg::ST_UPD_DR);
    assign bif.preset = ce_i && (s_q.st == tap_pkg::ST_RESET);
    assign bif.sin = tdi;

    always_comb
    begin
        s_d = s_q;
        // Only the second stage of the mode and data synchronisers is read; the clock edge uses its second and third.
        s_d.tck_s = {s_q.tck_s[1:0], tck_i};
        s_d.tms_s = {s_q.tms_s[0], tms_i};
        s_d.tdi_s = {s_q.tdi_s[0], tdi_i};
        if (rise_ev)
        begin
            s_d.st = nxt;
            s_d.ones = !tms ? 3'h0 : (s_q.ones == tap_pkg::RESET_ONES) ? s_q.ones
                       : s_q.ones + 3'h1;
            case (s_q.st)
                tap_pkg::ST_CAP_IR: s_d.ir_sh = {1'b0, tap_pkg::IR_CAPTURE_PAT};
                tap_pkg::ST_SHIFT_IR: s_d.ir_sh = {tdi, s_q.ir_sh[2:1]};
                tap_pkg::ST_UPD_IR: s_d.ir = s_q.ir_sh;
                tap_pkg::ST_CAP_DR:
                begin
                    s_d.byp = 1'b0;
                    if (sel_id)
                    begin
                        s_d.id_sh = ID_VALUE;
                    end
                end
                tap_pkg::ST_SHIFT_DR:
                begin
                    if (sel_id)
                    begin
                        s_d.id_sh = {tdi, s_q.id_sh[31:1]};
                    end
                    else if (!sel_bsr)
                    begin
                        s_d.byp = tdi;
                    end
                end
                default: s_d.ir = s_q.ir;
            endcase
            if (nxt == tap_pkg::ST_RESET)
            begin
                s_d.ir = tap_pkg::OP_IDCODE;
            end
        end
        if (fall_ev)
        begin
            if (s_q.st == tap_pkg::ST_SHIFT_IR)
            begin
                s_d.tdo = s_q.ir_sh[0];
            end
            else if (sel_id)
            begin
                s_d.tdo = s_q.id_sh[0];
            end
            else if (sel_bsr)
            begin
                s_d.tdo = bif.sout;
            end
            else
            begin
                s_d.tdo = s_q.byp;
            end
            s_d.tdo_oe = (s_q.st == tap_pkg::ST_SHIFT_IR)
                         || (s_q.st == tap_pkg::ST_SHIFT_DR);
        end
        // The output bus follows the instruction, and cell 108 under external test; the memory path itself is untouched.
        s_d.extest = (s_q.ir == tap_pkg::OP_EXTEST);
        if (s_q.ir == tap_pkg::OP_SAMPLE_Z)
        begin
            s_d.q_oe = 1'b0;
        end
        else if (s_q.ir == tap_pkg::OP_EXTEST)
        begin
            s_d.q_oe = bif.drive[tap_pkg::OE_CELL];
        end
        else
        begin
            s_d.q_oe = 1'b1;
        end
    end

    // Mode select and serial input reset high, as an undriven pad would read.
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q.tck_s <= 3'h0;
            s_q.tms_s <= 2'h3;
            s_q.tdi_s <= 2'h3;
            s_q.st <= tap_pkg::ST_RESET;
            s_q.ir_sh <= 3'h0;
            s_q.ir <= tap_pkg::OP_IDCODE;
            s_q.byp <= 1'b0;
            s_q.id_sh <= 32'h0000_0000;
            s_q.tdo <= 1'b0;
            s_q.tdo_oe <= 1'b0;
            s_q.q_oe <= 1'b1;
            s_q.extest <= 1'b0;
            s_q.ones <= 3'h0;
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    assign tdo_o = s_q.tdo;
    assign tdo_oe_o = s_q.tdo_oe;
    assign q_bus_oe_o = s_q.q_oe;
    assign extest_o = s_q.extest;
    assign pin_drive_o = bif.drive;

    a_tdo_on_fall: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ($changed(tdo_o) || $changed(tdo_oe_o)) |-> $past(fall_ev))
        else $error("serial output changed away from a falling test clock");

    a_oe_in_shift: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(tdo_oe_o) |-> ($past(s_q.st) == tap_pkg::ST_SHIFT_IR
                             || $past(s_q.st) == tap_pkg::ST_SHIFT_DR))
        else $error("serial output enabled outside a shift state");

    a_five_ones_reset: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (s_q.ones == tap_pkg::RESET_ONES) |-> (s_q.st == tap_pkg::ST_RESET))
        else $error("five high mode selects did not reach reset");

    a_reset_idcode: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (s_q.st == tap_pkg::ST_RESET) |-> (s_q.ir == tap_pkg::OP_IDCODE))
        else $error("instruction not identification read in reset state");

    a_capture_ir_pat: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (rise_ev && s_q.st == tap_pkg::ST_CAP_IR) |=> (s_q.ir_sh[1:0] == 2'h1))
        else $error("instruction capture pattern wrong");

    a_bypass_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (rise_ev && s_q.st == tap_pkg::ST_CAP_DR) |=> !s_q.byp)
        else $error("bypass not cleared on capture");

    a_id_capture: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (rise_ev && sel_id && s_q.st == tap_pkg::ST_CAP_DR)
        |=> (s_q.id_sh == ID_VALUE))
        else $error("identification value not captured");

    a_ir_at_update: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $changed(s_q.ir) |-> ($past(s_q.st) == tap_pkg::ST_UPD_IR
                              || s_q.st == tap_pkg::ST_RESET))
        else $error("instruction changed outside update");

    a_sample_z_float: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && s_q.ir == tap_pkg::OP_SAMPLE_Z) |=> !q_bus_oe_o)
        else $error("output bus not floated under sample with float");

    a_extest_oe_cell: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && s_q.ir == tap_pkg::OP_EXTEST)
        |=> (q_bus_oe_o == $past(bif.drive[tap_pkg::OE_CELL])))
        else $error("output bus enable does not follow cell 108");
endmodule
`default_nettype wire

// file: bench/scan_ctl.sv
// Board-level scan controller model that drives the test port pins.
`timescale 1ns/1ps
`default_nettype none
module scan_ctl (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic seen_o,
    output logic [1:0] seen_val_o
);
    logic tdo_w;

    // A floated serial output has no pull, so show the inverse instead of the stale bit.
    assign tdo_w = tdo_oe_i ? tdo_i : !tdo_i;

    initial
    begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h1;
        seen_o = 1'h0;
        seen_val_o = 2'h0;
    end

    // Signals change just after a fall and hold through the next rise; the clock rests low.
    task automatic step(input logic tms_v, input logic tdi_v, input logic look);
        tms_o = tms_v;
        tdi_o = tdi_v;
        #32 tck_o = 1'h1;
        if (look)
        begin
            seen_val_o = {tdo_oe_i, tdo_w};
            seen_o = 1'h1;
        end
        #32 tck_o = 1'h0;
        seen_o = 1'h0;
    endtask

    // Starts from idle, shifts n bits lsb first, passes update and returns to idle.
    task automatic scan(input logic ir, input int n, input logic [127:0] din);
        step(1'h1, 1'h1, 1'h0);
        if (ir)
            step(1'h1, 1'h1, 1'h0);
        step(1'h0, 1'h1, 1'h0);
        step(1'h0, 1'h1, 1'h0);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], 1'h1);
        step(1'h1, 1'h1, 1'h0);
        step(1'h0, 1'h1, 1'h0);
    endtask

    // Enters data shift, then five high mode-select rises are the fewest that reach reset.
    task automatic reset_tap();
        step(1'h1, 1'h1, 1'h0);
        step(1'h0, 1'h1, 1'h0);
        step(1'h0, 1'h1, 1'h0);
        repeat (5) step(1'h1, 1'h0, 1'h0);
        step(1'h0, 1'h1, 1'h0);
    endtask
endmodule
`default_nettype wire

// file: bench/boundary_scan_tap_tb.sv
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_tb;
    localparam int N = tap_pkg::BSR_LEN_DEF;
    localparam int OE = tap_pkg::OE_CELL;
    logic clk_sys_i;
    logic nrst_i;
    logic [N-1:0] pin_i;
    logic tck, tms, tdi, tdo, tdo_oe, seen;
    logic q_bus_oe_o, extest_o;
    logic ce;
    logic [N-1:0] pin_drive_o;
    logic [1:0] seen_val;
    logic [1:0] exp_q[$];
    logic [127:0] p;
    logic [127:0] want;
    logic [N-1:0] pre;
    logic [2:0] code;
    logic [2:0] codes [5];
    int n_fail = 0;
    int checked = 0;
    int seed = 32'he269;
    int len;

    tap_port uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .pin_i(pin_i), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .q_bus_oe_o(q_bus_oe_o), .extest_o(extest_o), .pin_drive_o(pin_drive_o));
    scan_ctl ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe),
        .seen_o(seen), .seen_val_o(seen_val));

    initial
    begin
        clk_sys_i = 1'h0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic expect_bits(input logic [127:0] v, input int n);
        for (int i = 0; i < n; i++)
            exp_q.push_back({1'h1, v[i]});
    endtask

    task automatic rnd();
        p = {$random(seed), $random(seed), $random(seed), $random(seed)};
    endtask

    // Identification value followed by the first shifted-in bits shows the msb-to-lsb path.
    task automatic read_id();
        rnd();
        expect_bits(128'(tap_pkg::ID_VALUE_DEF) | (p << 32), 40);
        ctl.scan(1'h0, 40, p);
        @(negedge clk_sys_i);
        check(128'(tdo_oe), 128'h0);
    endtask

    // Every bit seen on the serial output is judged against the oldest note, and fails when no note is left.
    always @(posedge seen)
    begin
        if (exp_q.size() == 0)
            check(128'(seen_val), 128'h4);
        else
            check(128'(seen_val), 128'(exp_q.pop_front()));
    end

    initial
    begin
        #200000;
        n_fail++;
        end_of_test();
    end

    initial
    begin
        // Reserved codes are never loaded by a well-behaved controller.
        codes = '{tap_pkg::OP_BYPASS, tap_pkg::OP_IDCODE, tap_pkg::OP_SAMPLE_Z,
                  tap_pkg::OP_SAMPLE, tap_pkg::OP_EXTEST};
        nrst_i = 1'h0;
        ce = 1'h1;
        pin_i = '0;
        pre = '0;
        pre[OE] = 1'h1;
        repeat (6) @(negedge clk_sys_i);
        check(128'(tdo_oe), 128'h0);
        nrst_i = 1'h1;
        repeat (2) @(negedge clk_sys_i);
        check(128'(q_bus_oe_o), 128'h1);
        check(128'(extest_o), 128'h0);
        check(128'(pin_drive_o), 128'(pre));
        ctl.step(1'h0, 1'h1, 1'h0);
        read_id();
        for (int i = 0; i < 5; i++)
        begin
            code = codes[i];
            rnd();
            @(negedge clk_sys_i);
            pin_i = p[N-1:0];
            expect_bits(128'(tap_pkg::IR_CAPTURE_PAT), 3);
            ctl.scan(1'h1, 3, 128'(code));
            @(negedge clk_sys_i);
            check(128'(extest_o), 128'(code == tap_pkg::OP_EXTEST));
            if (code == tap_pkg::OP_EXTEST)
                check(128'(q_bus_oe_o), 128'(pre[OE]));
            else
                check(128'(q_bus_oe_o), 128'(code != tap_pkg::OP_SAMPLE_Z));
            rnd();
            p[OE] = (code == tap_pkg::OP_EXTEST);
            len = N;
            want = 128'(pin_i);
            if (code == tap_pkg::OP_BYPASS)
                want = {p[126:0], 1'h0};
            if (code == tap_pkg::OP_IDCODE)
                want = 128'(tap_pkg::ID_VALUE_DEF) | (p << 32);
            if (code == tap_pkg::OP_BYPASS || code == tap_pkg::OP_IDCODE)
                len = 40;
            expect_bits(want, len);
            ctl.scan(1'h0, len, p);
            @(negedge clk_sys_i);
            if (code == tap_pkg::OP_SAMPLE || code == tap_pkg::OP_EXTEST)
            begin
                pre = p[N-1:0];
                check(128'(pin_drive_o), 128'(pre));
            end
            if (code == tap_pkg::OP_EXTEST)
                check(128'(q_bus_oe_o), 128'h1);
        end
        ctl.reset_tap();
        @(negedge clk_sys_i);
        check(128'(extest_o), 128'h0);
        check(128'(q_bus_oe_o), 128'h1);
        check(128'(pin_drive_o[OE]), 128'h1);
        // A test clock pulse while the clock enable is low must leave the controller idle.
        @(negedge clk_sys_i);
        ce = 1'h0;
        ctl.step(1'h1, 1'h1, 1'h0);
        @(negedge clk_sys_i);
        ce = 1'h1;
        check(128'(tdo_oe), 128'h0);
        check(128'(pin_drive_o[OE]), 128'h1);
        read_id();
        check(128'(exp_q.size()), 128'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
